// ### rtl/plsp_pkg.sv
// Constants for the link, slot and power-management register bank.
package plsp_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_DEV_CTRL_STATUS = 8'h70;
  localparam logic [7:0] OFS_LINK_CAP = 8'h74;
  localparam logic [7:0] OFS_LINK_CTRL = 8'h78;
  localparam logic [7:0] OFS_SLOT_CAP = 8'h7C;
  localparam int AUX_PM_EN_BIT = 10;
  localparam int AUX_DET_BIT = 20;
  localparam int ASPM_SUP_LO = 10;
  localparam int L0S_LAT_LO = 12;
  localparam int L1_LAT_LO = 15;
  localparam int ASPM_CTL_LO = 0;
  localparam int SLOT_SURPRISE_BIT = 5;
  localparam int SLOT_HP_CAP_BIT = 6;
  localparam int SLOT_PWR_VAL_LO = 7;
  localparam int SLOT_PWR_SCL_LO = 15;
  localparam logic [2:0] L0S_EXIT_LAT = 3'h5;
  localparam logic [2:0] L1_EXIT_LAT = 3'h5;
  localparam logic [1:0] ASPM_SUP_DEFAULT = 2'h3;
  localparam logic [1:0] ASPM_CTL_RESET = 2'h0;
  localparam logic [1:0] ASPM_L0S = 2'h1;
  localparam logic [1:0] ASPM_L1 = 2'h2;
endpackage

// ### rtl/plsp_aspm_gate.sv
// Turns the stored link control field into low-power entry permits.
`timescale 1ns/1ps
module plsp_aspm_gate
  import plsp_pkg::*;
(
  input wire logic [1:0] aspm_ctl,
  input wire logic [1:0] aspm_sup,
  output logic tx_l0s_allow,
  output logic rx_l0s_allow,
  output logic l1_allow
);
  // The tx L0s and L1 permits each need both the control enable and the advertised support.
  assign tx_l0s_allow = aspm_ctl[0] & aspm_sup[0];
  assign l1_allow = aspm_ctl[1] & aspm_sup[1];
  // The receiver follows the far transmitter, so it cannot be barred from L0s.
  assign rx_l0s_allow = 1'b1;
endmodule

// ### rtl/plsp_regs.sv
// Register bank for aux power, link capability/control and slot capability.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module plsp_regs
  import plsp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [plsp_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic reverse_mode,
  input wire logic [1:0] aspm_support,
  input wire logic [6:0] slot_flags,
  input wire logic [7:0] slot_power_value,
  input wire logic [1:0] slot_power_scale,
  output logic [1:0] aspm_ctl,
  output logic tx_l0s_allow,
  output logic rx_l0s_allow,
  output logic l1_allow
);
  import plsp_pkg::*;

  logic [1:0] sup_q;
  logic [6:0] flags_q;
  logic [7:0] pval_q;
  logic [1:0] pscl_q;
  logic rev_q;
  logic [31:0] next_rdata;
  wire [1:0] sup_eff;
  wire [31:0] dev_word;
  wire [31:0] lcap_word;
  wire [31:0] lctl_word;
  wire [31:0] slot_word;
  wire hit_ctl;

  // Straps are static; sampled by clock after reset so reset loads constants only.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sup_q <= ASPM_SUP_DEFAULT;
      flags_q <= 7'h00;
      pval_q <= 8'h00;
      pscl_q <= 2'h0;
      rev_q <= 1'b0;
    end
    else
    begin
      sup_q <= aspm_support;
      flags_q <= slot_flags;
      pval_q <= slot_power_value;
      pscl_q <= slot_power_scale;
      rev_q <= reverse_mode;
    end
  end

  // Code 00b is reserved, so fall back to reporting both states.
  assign sup_eff = (sup_q == 2'h0) ? ASPM_SUP_DEFAULT : sup_q;
  assign dev_word = 32'h0000_0000;
  assign lcap_word = (32'(sup_eff) << ASPM_SUP_LO)
                   | (32'(L0S_EXIT_LAT) << L0S_LAT_LO)
                   | (32'(L1_EXIT_LAT) << L1_LAT_LO);
  assign lctl_word = 32'(aspm_ctl) << ASPM_CTL_LO;
  // Presence bits 0-4, surprise bit 5, hot-plug bit 6 sit in strap order.
  assign slot_word = rev_q ?
                     (32'(flags_q)
                     | (32'(pval_q) << SLOT_PWR_VAL_LO)
                     | (32'(pscl_q) << SLOT_PWR_SCL_LO))
                     : 32'h0000_0000;
  assign hit_ctl = wr & (addr == OFS_LINK_CTRL);

  // Only the control field stores writes; other offsets drop them.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      aspm_ctl <= ASPM_CTL_RESET;
    else if (hit_ctl)
      aspm_ctl <= wdata[ASPM_CTL_LO+1:ASPM_CTL_LO];
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (rd)
    begin
      unique case (addr)
        OFS_DEV_CTRL_STATUS: next_rdata = dev_word;
        OFS_LINK_CAP: next_rdata = lcap_word;
        OFS_LINK_CTRL: next_rdata = lctl_word;
        OFS_SLOT_CAP: next_rdata = slot_word;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata <= 32'h0000_0000;
    else
      rdata <= next_rdata;
  end

  plsp_aspm_gate u_gate (
    .aspm_ctl(aspm_ctl),
    .aspm_sup(sup_eff),
    .tx_l0s_allow(tx_l0s_allow),
    .rx_l0s_allow(rx_l0s_allow),
    .l1_allow(l1_allow)
  );
endmodule

// ### verif/plsp_regs_assertions.sv
// Checker for the link, slot and power register bank ports.
`timescale 1ns/1ps
module plsp_regs_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic reverse_mode,
  input wire logic [1:0] aspm_ctl,
  input wire logic tx_l0s_allow,
  input wire logic rx_l0s_allow,
  input wire logic l1_allow
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence ctl_write;
    wr && addr == 8'h78;
  endsequence
  chk_rx_always: assert property (rx_l0s_allow) else $error("rx l0s low");
  chk_l1_gate: assert property (l1_allow |-> aspm_ctl[1]) else $error("l1 open");
  chk_l0s_gate: assert property (tx_l0s_allow |-> aspm_ctl[0]) else $error("l0s open");
  chk_ctl_store: assert property (ctl_write |=> aspm_ctl == $past(wdata[1:0]))
    else $error("ctl not stored");
  chk_ctl_hold: assert property (!wr |=> $stable(aspm_ctl)) else $error("ctl moved");
  chk_aux_zero: assert property (rd && addr == 8'h70 |=> rdata[10] == 0 && rdata[20] == 0)
    else $error("aux bit set");
  chk_exit_lat: assert property (rd && addr == 8'h74 |=> rdata[17:12] == 6'h2D)
    else $error("bad latency");
  chk_slot_off: assert property (!reverse_mode[*2] ##0 rd && addr == 8'h7C |=> rdata == 0)
    else $error("slot cap shown");
  chk_idle_zero: assert property (!rd |=> rdata == 0) else $error("rdata not idle");
endmodule
bind plsp_regs plsp_regs_chk chk (.*);

// ### verif/pcie_link_slot_pm_regs_test.sv
// Testbench for the link, slot and power register bank.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
module pcie_link_slot_pm_regs_test;
  logic clock = 0, nrst = 0, wr = 0, rd = 0, reverse_mode = 0;
  logic [7:0] addr = 8'h00, slot_power_value = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] aspm_support = 2'h3, slot_power_scale = 2'h0, aspm_ctl;
  logic [6:0] slot_flags = 7'h00;
  logic tx_l0s_allow, rx_l0s_allow, l1_allow;
  int errors = 0, total_checks = 0;
  plsp_regs uut (.*);
  initial forever #20 clock = ~clock;
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #2000000;
    errors++;
    close_out();
  end
  initial
  begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    wr_reg(8'h70, 32'hFFFFFFFF);
    rd_chk(8'h70, 32'h0);
    wr_reg(8'h74, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      aspm_support <= 2'(s);
      repeat (2) @(posedge clock);
      rd_chk(8'h74, 32'h2D000 | ((s == 0 ? 32'h3 : 32'(s)) << 10));
    end
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(8'h78, 32'hFFFFFFFC | 32'(c));
      rd_chk(8'h78, 32'(c));
      `CHK({l1_allow, tx_l0s_allow, rx_l0s_allow}, {2'(c), 1'b1})
    end
    // A reset in mid-run must clear the stored control field again.
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `CHK({aspm_ctl, l1_allow, tx_l0s_allow, rx_l0s_allow}, 5'h01)
    @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    rd_chk(8'h78, 32'h0);
    reverse_mode <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      slot_flags <= k[0] ? 7'h55 : 7'h2A;
      slot_power_value <= k[1] ? 8'h19 : 8'hE6;
      slot_power_scale <= 2'(k);
      wr_reg(8'h7C, 32'h0);
      @(posedge clock);
      rd_chk(8'h7C, 32'({2'(k), k[1] ? 8'h19 : 8'hE6, k[0] ? 7'h55 : 7'h2A}));
    end
    reverse_mode <= 1'b0;
    repeat (2) @(posedge clock);
    rd_chk(8'h7C, 32'h0);
    rd_chk(8'h80, 32'h0);
    close_out();
  end
endmodule
